/* File: hdl/rum_map.svh */
// register selects, field positions, reset values and event codes of the usage monitor
`ifndef RUM_MAP_SVH
`define RUM_MAP_SVH

// =====================================================
// register selects on the special register port
`define RUM_SEL_W          2
`define RUM_SEL_ASSOC      2'h0
`define RUM_SEL_EVTSEL     2'h1
`define RUM_SEL_CTR        2'h2

// =====================================================
// reset values
`define RUM_ASSOC_RST      64'h0
`define RUM_EVTSEL_RST     64'h0

// =====================================================
// field positions
`define RUM_WORD_W         64
`define RUM_EVT_LSB        0
`define RUM_EVT_W          8
`define RUM_ESEL_TAG_LSB   32
`define RUM_TAG_MAX_W      10
`define RUM_CTR_ERR_BIT    63
`define RUM_CTR_UNAV_BIT   62
`define RUM_CTR_OVF_BIT    61
`define RUM_DATA_W         62

// =====================================================
// widths, limits and event codes
`define RUM_BW_W           24
`define RUM_MAX_TAG        63
`define RUM_EVT_OCC        8'h01
`define RUM_EVT_TOT        8'h02
`define RUM_EVT_LOC        8'h03
`define RUM_EVT_SUPPORT    3'h7

`endif

/* File: hdl/rum_pkg.sv */
// types shared by the usage monitor modules
`default_nettype none
package rum_pkg;
	// =====================================================
	// access phase of the special register port
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_ANSWER
	} rum_phase_t;

	// 64-bit register word and event code
	typedef logic [63:0] rum_word_t;
	typedef logic [7:0]  rum_evt_code_t;
endpackage : rum_pkg
`default_nettype wire

/* File: hdl/rum_write_check.sv */
// fault check for special register writes to the usage monitor
`timescale 1ns/1ps
`default_nettype none
`include "rum_map.svh"
module rum_write_check
	import rum_pkg::*;
#(
	parameter int TAG_W   = 6,
	parameter int MAX_TAG = `RUM_MAX_TAG
) (
	// write request
	input  wire logic [`RUM_SEL_W-1:0] sel,
	input  wire rum_word_t             wdata,
	// result
	output logic                       fault
);
	// writable bits of each register
	localparam rum_word_t TAG_MASK   = (64'h1 << TAG_W) - 64'h1;
	localparam rum_word_t ASSOC_OK   = TAG_MASK;
	localparam rum_word_t ESEL_OK    = 64'hFF | (TAG_MASK << `RUM_ESEL_TAG_LSB);

	// tag above the highest supported one
	function automatic logic tag_over(input logic [`RUM_TAG_MAX_W-1:0] t);
		tag_over = (32'(t) > MAX_TAG);
	endfunction : tag_over

	// =====================================================
	// fault decode
	always_comb begin
		case (sel)
			`RUM_SEL_ASSOC: begin
				fault = (|(wdata & ~ASSOC_OK)) | tag_over(wdata[`RUM_TAG_MAX_W-1:0]); // see R5 see R18
			end
			`RUM_SEL_EVTSEL: begin
				fault = (|(wdata & ~ESEL_OK))
					| tag_over(wdata[`RUM_ESEL_TAG_LSB +: `RUM_TAG_MAX_W]); // see R18
			end
			default: begin
				fault = 1'b1; // readout is read only, select 3 unmapped
			end
		endcase
	end
endmodule : rum_write_check
`default_nettype wire

/* File: hdl/rum_counter_bank.sv */
// package-wide counters indexed by monitoring tag
`timescale 1ns/1ps
`default_nettype none
`include "rum_map.svh"
module rum_counter_bank
	import rum_pkg::*;
#(
	parameter int TAG_W  = 6,
	parameter int NUM_LP = 2,
	parameter int BW_W   = `RUM_BW_W,
	parameter int OCC_W  = `RUM_BW_W
) (
	// clock and reset
	input  wire logic                              core_clk,
	input  wire logic                              rst_n,
	// stamped operations
	input  wire logic [NUM_LP-1:0]                 fill_v,
	input  wire logic [NUM_LP-1:0]                 tot_v,
	input  wire logic [NUM_LP-1:0]                 loc_v,
	input  wire logic [NUM_LP-1:0][TAG_W-1:0]      tags,
	// eviction report
	input  wire logic                              evict_v,
	input  wire logic [TAG_W-1:0]                  evict_tag,
	// read port
	input  wire logic [TAG_W-1:0]                  rd_tag,
	input  wire rum_evt_code_t                     rd_evt,
	input  wire logic                              rd_take,
	output logic [`RUM_DATA_W-1:0]                 rd_data,
	output logic                                   rd_unavail,
	output logic                                   rd_ovf
);
	localparam int DEPTH = 1 << TAG_W;

	// all counter state
	typedef struct packed {
		logic [DEPTH-1:0][OCC_W-1:0] occ;   // occupancy units
		logic [DEPTH-1:0][BW_W-1:0]  tot;   // total external traffic
		logic [DEPTH-1:0][BW_W-1:0]  loc;   // local external traffic
		logic [DEPTH-1:0]            seen;  // tag has data
		logic [DEPTH-1:0]            ovf_t; // total wrapped
		logic [DEPTH-1:0]            ovf_l; // local wrapped
	} rum_bank_t;

	rum_bank_t s_q;
	rum_bank_t s_d;

	// =====================================================
	// counting, indexed only by tag so every processor shares it
	always_comb begin
		logic [BW_W:0] sum;
		sum = '0;
		s_d = s_q;
		// clear on read first so a wrap in the same cycle wins
		if (rd_take && rd_evt == `RUM_EVT_TOT) begin
			s_d.ovf_t[rd_tag] = 1'b0; // see R13
		end
		if (rd_take && rd_evt == `RUM_EVT_LOC) begin
			s_d.ovf_l[rd_tag] = 1'b0; // see R13
		end
		for (int i = 0; i < NUM_LP; i++) begin
			if (fill_v[i]) begin
				s_d.occ[tags[i]]  = s_d.occ[tags[i]] + OCC_W'(1); // see R6
				s_d.seen[tags[i]] = 1'b1;
			end
			if (tot_v[i]) begin
				sum = {1'b0, s_d.tot[tags[i]]} + (BW_W+1)'(1);
				s_d.tot[tags[i]]  = sum[BW_W-1:0]; // see R20
				s_d.seen[tags[i]] = 1'b1;
				if (sum[BW_W]) begin
					s_d.ovf_t[tags[i]] = 1'b1; // see R13
				end
			end
			if (loc_v[i]) begin
				sum = {1'b0, s_d.loc[tags[i]]} + (BW_W+1)'(1);
				s_d.loc[tags[i]]  = sum[BW_W-1:0]; // see R20
				s_d.seen[tags[i]] = 1'b1;
				if (sum[BW_W]) begin
					s_d.ovf_l[tags[i]] = 1'b1; // see R13
				end
			end
		end
		// evicted lines leave the owner's occupancy, never below zero
		if (evict_v && s_d.occ[evict_tag] != '0) begin
			s_d.occ[evict_tag] = s_d.occ[evict_tag] - OCC_W'(1);
		end
	end

	// =====================================================
	// read mux
	always_comb begin
		rd_unavail = ~s_q.seen[rd_tag]; // see R11
		case (rd_evt)
			`RUM_EVT_OCC: begin
				rd_data = {{(`RUM_DATA_W-OCC_W){1'b0}}, s_q.occ[rd_tag]};
				rd_ovf  = 1'b0;
			end
			`RUM_EVT_TOT: begin
				rd_data = {{(`RUM_DATA_W-BW_W){1'b0}}, s_q.tot[rd_tag]};
				rd_ovf  = s_q.ovf_t[rd_tag];
			end
			`RUM_EVT_LOC: begin
				rd_data = {{(`RUM_DATA_W-BW_W){1'b0}}, s_q.loc[rd_tag]};
				rd_ovf  = s_q.ovf_l[rd_tag];
			end
			default: begin
				rd_data = '0;
				rd_ovf  = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : rum_counter_bank
`default_nettype wire

/* File: hdl/rum_top.sv */
// shared-resource usage monitor: tag association, event select and counter readout
//
// Notes on behaviour
// R1: stamp each processor operation with its tag
// R2: tag width is clog2 of highest tag plus one
// R3: association register is zero after reset
// R4: tag field at most ten bits, binary
// R5: association tag above maximum faults, no effect
// R6: tags and counts shared across all processors
// R7: event code bits 7:0, tag bits 41:32
// R8: event-select tag width equals association width
// R9: codes 01,02,03 decoded; others unsupported
// R10: unsupported selection sets error bit 63
// R11: no data for tag sets bit 62
// R12: data valid only when 63,62 clear
// R13: overflow bit 61 on wrap, cleared by read
// R14: no interrupt; data only by reading
// R15: separate from general performance counters
// R16: software locks select-then-read sequence
// R17: select and association accessible any time
// R18: reserved bit changes fault, no effect
// R19: management mode leaves tag and counts unchanged
// R20: bandwidth counters are 24 bits wide
// R21: readout follows the latest selection immediately
`timescale 1ns/1ps
`default_nettype none
`include "rum_map.svh"
module rum_top
	import rum_pkg::*;
#(
	parameter int LP_W        = 1,
	parameter int MAX_TAG     = `RUM_MAX_TAG,
	parameter int BW_W        = `RUM_BW_W,
	parameter int OCC_W       = `RUM_BW_W,
	parameter bit OVF_EN      = 1'b1,
	parameter logic [2:0] EVT_SUPPORT = `RUM_EVT_SUPPORT,
	// derived, do not override
	// tag width at least one bit, at most ten
	parameter int NUM_LP      = 1 << LP_W,
	parameter int TAG_W_RAW   = $clog2(MAX_TAG + 1),
	parameter int TAG_W       = (TAG_W_RAW < 1) ? 1 :
		((TAG_W_RAW > `RUM_TAG_MAX_W) ? `RUM_TAG_MAX_W : TAG_W_RAW) // see R2 see R4
) (
	// clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	// special register access
	input  wire logic                          sr_req,
	input  wire logic                          sr_write,
	input  wire logic [`RUM_SEL_W-1:0]         sr_sel,
	input  wire logic [LP_W-1:0]               sr_lp,
	input  wire rum_word_t                     sr_wdata,
	output logic                               sr_ack_q,
	output logic                               sr_fault_q,
	output rum_word_t                          sr_rdata_q,
	// operations issued by each processor
	input  wire logic [NUM_LP-1:0]             op_fill,
	input  wire logic [NUM_LP-1:0]             op_ext_total,
	input  wire logic [NUM_LP-1:0]             op_ext_local,
	// eviction report from the shared cache
	input  wire logic                          evict_valid,
	input  wire logic [TAG_W-1:0]              evict_tag,
	// stamped requests toward the cache
	output logic [NUM_LP-1:0]                  req_valid_q,
	output logic [NUM_LP-1:0][TAG_W-1:0]       req_tag_q
);

	// =====================================================
	// state of the block
	typedef struct packed {
		// access port
		rum_phase_t                 phase;    // access phase
		logic                       ack;      // answer strobe
		logic                       fault;    // protection fault
		rum_word_t                  rdata;    // read answer
		// per-processor registers
		logic [NUM_LP-1:0][TAG_W-1:0] assoc;  // active tag per processor
		logic [NUM_LP-1:0][TAG_W-1:0] esel_tag; // selected tag
		logic [NUM_LP-1:0][7:0]     esel_evt; // selected event code
		// stamping stage
		logic [NUM_LP-1:0]          st_fill;  // stamped fill
		logic [NUM_LP-1:0]          st_tot;   // stamped total traffic
		logic [NUM_LP-1:0]          st_loc;   // stamped local traffic
		logic [NUM_LP-1:0]          req_v;    // stamped request valid
		logic [NUM_LP-1:0][TAG_W-1:0] req_tag; // stamped request tag
	} rum_state_t;

	rum_state_t s_q;   // registered state
	rum_state_t s_d;   // next state

	// =====================================================
	// wires between the parts
	logic                          wr_fault;   // write would fault
	logic [TAG_W-1:0]              rd_tag;     // selection of this access
	rum_evt_code_t                 rd_evt;     // event of this access
	logic                          rd_take;    // readout is consumed
	logic [`RUM_DATA_W-1:0]        rd_data;    // counter value
	logic                          rd_unavail; // tag has no data
	logic                          rd_ovf;     // counter wrapped

	// =====================================================
	// decode of a supported event code
	// each of the three decoded codes can be masked off by EVT_SUPPORT
	function automatic logic evt_supported(input rum_evt_code_t code);
		case (code)
			// cache occupancy
			`RUM_EVT_OCC: begin
				evt_supported = EVT_SUPPORT[0]; // see R9
			end
			// total external traffic
			`RUM_EVT_TOT: begin
				evt_supported = EVT_SUPPORT[1]; // see R9
			end
			// local external traffic
			`RUM_EVT_LOC: begin
				evt_supported = EVT_SUPPORT[2]; // see R9
			end
			// every other code
			default: begin
				evt_supported = 1'b0; // reserved codes, see R9
			end
		endcase
	endfunction : evt_supported

	// build the readout word from counter data and flags
	function automatic rum_word_t ctr_word(
		input logic                   err,
		input logic                   unav,
		input logic                   ovf,
		input logic [`RUM_DATA_W-1:0] data
	);
		rum_word_t w;
		// flags and data start cleared
		w = '0;
		// error wins over unavailable
		if (err) begin
			// unsupported event code
			w[`RUM_CTR_ERR_BIT] = 1'b1; // see R10
		end else if (unav) begin
			// tag never stamped since reset
			w[`RUM_CTR_UNAV_BIT] = 1'b1; // see R11
		end else begin
			// data only when both flags clear, see R12
			w[`RUM_DATA_W-1:0] = data;
			// flag bit only when enabled
			if (OVF_EN) begin
				w[`RUM_CTR_OVF_BIT] = ovf; // see R13
			end
		end
		ctr_word = w;
	endfunction : ctr_word

	// event-select word as software sees it
	function automatic rum_word_t esel_word(
		input rum_evt_code_t    evt,
		input logic [TAG_W-1:0] tag
	);
		rum_word_t w;
		// unused bits read as zero
		w = '0;
		w[`RUM_EVT_LSB +: `RUM_EVT_W] = evt;     // see R7
		// tag field is TAG_W wide
		w[`RUM_ESEL_TAG_LSB +: TAG_W] = tag;     // see R7 see R8
		esel_word = w;
	endfunction : esel_word

	// =====================================================
	// write fault check
	rum_write_check #(
		.TAG_W   (TAG_W),
		.MAX_TAG (MAX_TAG)
	) u_check (
		// fault decode is purely combinational
		.sel   (sr_sel),
		.wdata (sr_wdata),
		.fault (wr_fault)
	);

	// =====================================================
	// package-wide counters, kept apart from the general
	// performance counters so both run side by side
	rum_counter_bank #(
		.TAG_W  (TAG_W),
		.NUM_LP (NUM_LP),
		.BW_W   (BW_W),
		.OCC_W  (OCC_W)
	) u_bank (
		// clock and reset
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		// stamped operations
		.fill_v     (s_q.st_fill),
		.tot_v      (s_q.st_tot),
		.loc_v      (s_q.st_loc),
		.tags       (s_q.req_tag),
		// eviction from the cache
		.evict_v    (evict_valid),
		.evict_tag  (evict_tag),
		// readout of the current selection
		.rd_tag     (rd_tag),
		.rd_evt     (rd_evt),
		.rd_take    (rd_take),
		.rd_data    (rd_data),
		.rd_unavail (rd_unavail),
		.rd_ovf     (rd_ovf)
	); // see R15

	// readout always looks at the current selection, see R21
	// the processor named by sr_lp picks the pair
	assign rd_tag = s_q.esel_tag[sr_lp];
	assign rd_evt = s_q.esel_evt[sr_lp];

	// =====================================================
	// next-state logic
	// stamping, access decode and answer
	always_comb begin
		// hold everything by default
		s_d     = s_q;
		// no readout consumed by default
		rd_take = 1'b0;
		// answer strobe lasts one cycle
		s_d.ack = 1'b0;

		// stamp every operation with the processor's tag
		// tag before any write landing on this edge
		for (int lp = 0; lp < NUM_LP; lp++) begin
			// kinds pass one register stage
			s_d.st_fill[lp] = op_fill[lp];
			s_d.st_tot[lp]  = op_ext_total[lp];
			s_d.st_loc[lp]  = op_ext_local[lp];
			// any kind makes a cache request
			s_d.req_v[lp]   = op_fill[lp] | op_ext_total[lp] | op_ext_local[lp];
			// tag of this processor
			s_d.req_tag[lp] = s_q.assoc[lp]; // see R1
		end

		// access handling; the tag only moves by a write here,
		// so management mode keeps both tag and counts, see R19
		case (s_q.phase)
			// waiting for a request
			ST_IDLE: begin
				// accepted whenever idle, at any point of execution
				if (sr_req) begin // see R17
					// answer in the next cycle
					s_d.phase = ST_ANSWER;
					// strobe for one cycle
					s_d.ack   = 1'b1;
					// last answer dropped
					s_d.fault = 1'b0;
					s_d.rdata = '0;
					if (sr_write) begin
						// write path
						// a faulting write changes nothing
						if (wr_fault) begin
							// reserved bit, tag over range, or readout or unmapped select
							s_d.fault = 1'b1; // see R5 see R18
						end else begin
							// clean write lands on this edge
							case (sr_sel)
								// tag used from the next operation
								`RUM_SEL_ASSOC: begin
									s_d.assoc[sr_lp] = sr_wdata[TAG_W-1:0];
								end
								// code and tag move together
								`RUM_SEL_EVTSEL: begin
									s_d.esel_evt[sr_lp] = sr_wdata[`RUM_EVT_LSB +: `RUM_EVT_W]; // see R7
									s_d.esel_tag[sr_lp] = sr_wdata[`RUM_ESEL_TAG_LSB +: TAG_W]; // see R8
								end
								// already refused by the check
								default: begin
									s_d.fault = 1'b1;
								end
							endcase
						end
					end else begin
						// read path
						case (sr_sel)
							// tag in the low bits
							`RUM_SEL_ASSOC: begin
								// upper bits read as zero
								s_d.rdata = {{(`RUM_WORD_W-TAG_W){1'b0}}, s_q.assoc[sr_lp]};
							end
							// code and tag fields
							`RUM_SEL_EVTSEL: begin
								// selection of this processor
								s_d.rdata = esel_word(rd_evt, rd_tag);
							end
							// flags and data of the selection
							`RUM_SEL_CTR: begin
								// any processor reads any tag's data, see R6
								// polled only, no interrupt path exists, see R14
								// the read also clears the overflow
								// flag of the selected pair
								// error from the code, data from the bank
								s_d.rdata = ctr_word(~evt_supported(rd_evt), rd_unavail, rd_ovf, rd_data);
								rd_take   = OVF_EN; // see R13
							end
							// unmapped select
							default: begin
								s_d.fault = 1'b1;
							end
						endcase
					end
				end
			end
			// answer cycle
			ST_ANSWER: begin
				// requests in the answer cycle are ignored
				// a request still held after this cycle is taken again
				// idle again next cycle
				s_d.phase = ST_IDLE;
			end
			// unknown phase recovers
			default: begin
				// back to idle
				s_d.phase = ST_IDLE;
			end
		endcase
	end

	// =====================================================
	// state register
	// every register runs on every edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q       <= '0; // association cleared, see R3
			// phase explicitly idle
			s_q.phase <= ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// =====================================================
	// outputs straight from the state register
	// answer port
	assign sr_ack_q    = s_q.ack;
	assign sr_fault_q  = s_q.fault;
	assign sr_rdata_q  = s_q.rdata;
	// stamped requests
	assign req_valid_q = s_q.req_v;
	assign req_tag_q   = s_q.req_tag;

endmodule : rum_top
`default_nettype wire

/* File: tb/rum_top_assertions.sv */
// port checker for the usage monitor
`timescale 1ns/1ps
`default_nettype none
`include "rum_map.svh"
module rum_top_assertions
	import rum_pkg::*;
#(
	parameter int LP_W    = 1,
	parameter int NUM_LP  = 2,
	parameter int TAG_W   = 6,
	parameter int MAX_TAG = 63
) (
	// clock and reset
	input wire logic                  core_clk,
	input wire logic                  rst_n,
	// register port
	input wire logic                  sr_req,
	input wire logic                  sr_write,
	input wire logic [`RUM_SEL_W-1:0] sr_sel,
	input wire rum_word_t             sr_wdata,
	input wire logic                  sr_ack_q,
	input wire logic                  sr_fault_q,
	input wire rum_word_t             sr_rdata_q,
	// operations and stamps
	input wire logic [NUM_LP-1:0]     op_fill,
	input wire logic [NUM_LP-1:0]     op_ext_total,
	input wire logic [NUM_LP-1:0]     op_ext_local,
	input wire logic [NUM_LP-1:0]     req_valid_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// =====================================================
	// helpers
	logic              taken; // request accepted at this edge
	logic [NUM_LP-1:0] any_op; // any operation per processor
	assign taken  = sr_req && !sr_ack_q;
	assign any_op = op_fill | op_ext_total | op_ext_local;
	// =====================================================
	// properties
	property p_ack_pulse; taken |=> sr_ack_q ##1 !sr_ack_q; endproperty
	property p_ack_cause; sr_ack_q |-> $past(taken); endproperty
	property p_ctr_wr; taken && sr_write && sr_sel == `RUM_SEL_CTR |=> sr_fault_q && sr_rdata_q == 64'h0; endproperty
	property p_tag_big; taken && sr_write && sr_sel == `RUM_SEL_ASSOC && sr_wdata > MAX_TAG |=> sr_fault_q; endproperty
	property p_rsv; taken && sr_write && sr_sel == `RUM_SEL_EVTSEL && sr_wdata[31:8] != 24'h0 |=> sr_fault_q; endproperty
	property p_err; sr_ack_q && sr_rdata_q[63] |-> sr_rdata_q[62:0] == 63'h0; endproperty
	property p_unav; sr_ack_q && sr_rdata_q[62] |-> !sr_rdata_q[63] && sr_rdata_q[61:0] == 62'h0; endproperty
	property p_hold; !taken |=> $stable(sr_rdata_q) && $stable(sr_fault_q); endproperty
	property p_stamp; any_op != '0 |=> req_valid_q == $past(any_op); endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle after request");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_ctr_wr: assert property (p_ctr_wr) else $error("readout write not refused");
	a_tag_big: assert property (p_tag_big) else $error("oversized tag not refused");
	a_rsv: assert property (p_rsv) else $error("reserved bits not refused");
	a_err: assert property (p_err) else $error("error word carries data");
	a_unav: assert property (p_unav) else $error("unavailable word carries data");
	a_hold: assert property (p_hold) else $error("answer changed without request");
	a_stamp: assert property (p_stamp) else $error("operation not stamped");
	// =====================================================
	// covers
	c_fault: cover property (sr_ack_q && sr_fault_q);
	c_ovf: cover property (sr_ack_q && sr_rdata_q[61]);
	c_dual: cover property (op_fill == 2'h3);
endmodule : rum_top_assertions
bind rum_top rum_top_assertions #(.LP_W(LP_W), .NUM_LP(NUM_LP), .TAG_W(TAG_W), .MAX_TAG(MAX_TAG)) u_rum_top_assertions (
	.core_clk(core_clk), .rst_n(rst_n), .sr_req(sr_req), .sr_write(sr_write), .sr_sel(sr_sel),
	.sr_wdata(sr_wdata), .sr_ack_q(sr_ack_q), .sr_fault_q(sr_fault_q), .sr_rdata_q(sr_rdata_q),
	.op_fill(op_fill), .op_ext_total(op_ext_total), .op_ext_local(op_ext_local), .req_valid_q(req_valid_q));
`default_nettype wire

/* File: tb/test_rum_top.sv */
// self-checking bench for the usage monitor
`timescale 1ns/1ps
`default_nettype none
`include "rum_map.svh"
module test_rum_top
	import rum_pkg::*;
;
	localparam int BW = 4; // short bandwidth counter so a wrap fits
	localparam int TW = 6; // tag width for highest tag 63
	// =====================================================
	// stimulus and observation
	logic                 core_clk     = 1'b0;
	logic                 rst_n        = 1'b0;
	logic                 sr_req       = 1'b0;
	logic                 sr_write     = 1'b0;
	logic [1:0]           sr_sel       = 2'h0;
	logic                 sr_lp        = 1'b0;
	rum_word_t            sr_wdata     = 64'h0;
	logic [1:0]           op_fill      = 2'h0;
	logic [1:0]           op_ext_total = 2'h0;
	logic [1:0]           op_ext_local = 2'h0;
	logic                 evict_valid  = 1'b0;
	logic [TW-1:0]        evict_tag    = 6'h0;
	logic                 sr_ack_q;
	logic                 sr_fault_q;
	rum_word_t            sr_rdata_q;
	logic [1:0]           req_valid_q;
	logic [1:0][TW-1:0]   req_tag_q;
	rum_word_t            rd; // last answer word
	logic                 flt; // last fault flag
	int                   err_count    = 0;
	int                   tests_run    = 0;
	rum_evt_code_t        bad[4]       = '{8'h00, 8'h04, 8'h80, 8'hFF};
	// clock
	always #4 core_clk = ~core_clk;
	rum_top #(.MAX_TAG(63), .BW_W(BW)) u_rum_top (
		.core_clk(core_clk), .rst_n(rst_n), .sr_req(sr_req), .sr_write(sr_write), .sr_sel(sr_sel),
		.sr_lp(sr_lp), .sr_wdata(sr_wdata), .sr_ack_q(sr_ack_q), .sr_fault_q(sr_fault_q),
		.sr_rdata_q(sr_rdata_q), .op_fill(op_fill), .op_ext_total(op_ext_total),
		.op_ext_local(op_ext_local), .evict_valid(evict_valid), .evict_tag(evict_tag),
		.req_valid_q(req_valid_q), .req_tag_q(req_tag_q));
	// =====================================================
	// compare and access tasks
	task automatic chk_word(input rum_word_t got, input rum_word_t exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: word %h, want %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_flag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: flag %b, want %b", $time, got, exp);
		end
	endtask : chk_flag
	// one access: hold request until the answer is seen
	task automatic acc(input logic w, input logic [1:0] sel, input logic lp, input rum_word_t d);
		int n;
		n = 0;
		@(negedge core_clk);
		sr_req = 1'b1;
		sr_write = w;
		sr_sel = sel;
		sr_lp = lp;
		sr_wdata = d;
		do begin
			@(negedge core_clk);
			n++;
		end while (sr_ack_q !== 1'b1 && n < 10);
		if (n >= 10) chk_flag(1'b0, 1'b1);
		rd = sr_rdata_q;
		flt = sr_fault_q;
		// hold the request across the answer-cycle edge, where it is ignored
		@(negedge core_clk);
		sr_req = 1'b0;
	endtask : acc
	task automatic wr(input logic [1:0] sel, input logic lp, input rum_word_t d, input logic ef);
		acc(1'b1, sel, lp, d);
		chk_flag(flt, ef);
	endtask : wr
	task automatic rdck(input logic [1:0] sel, input logic lp, input rum_word_t exp);
		acc(1'b0, sel, lp, 64'h0);
		chk_word(rd, exp);
	endtask : rdck
	// select tag and code, then read the readout
	task automatic ctr(input logic lp, input logic [TW-1:0] tg, input rum_evt_code_t c, input rum_word_t exp);
		wr(`RUM_SEL_EVTSEL, lp, {22'h0, 4'h0, tg, 24'h0, c}, 1'b0);
		rdck(`RUM_SEL_CTR, lp, exp);
	endtask : ctr
	// drive operations for n cycles, checking the stamps
	task automatic ops(input logic [1:0] f, t, l, input int n, input logic [TW-1:0] tg);
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk);
			if (i > 0) chk_word(64'(req_valid_q), 64'(f | t | l));
			if (i > 0 && (f[0] | t[0] | l[0])) chk_word(64'(req_tag_q[0]), 64'(tg));
			op_fill = f;
			op_ext_total = t;
			op_ext_local = l;
		end
		@(negedge core_clk);
		op_fill = 2'h0;
		op_ext_total = 2'h0;
		op_ext_local = 2'h0;
		repeat (2) @(negedge core_clk);
	endtask : ops
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	// =====================================================
	// watchdog
	initial begin
		#20000;
		err_count++;
		stop_test();
	end
	// =====================================================
	// main sequence
	initial begin
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
		rdck(`RUM_SEL_ASSOC, 1'b0, 64'h0);
		rdck(`RUM_SEL_ASSOC, 1'b1, 64'h0);
		wr(`RUM_SEL_ASSOC, 1'b0, 64'h5, 1'b0);
		wr(`RUM_SEL_ASSOC, 1'b0, 64'h40, 1'b1);
		wr(`RUM_SEL_ASSOC, 1'b0, 64'h0010_0005, 1'b1);
		rdck(`RUM_SEL_ASSOC, 1'b0, 64'h5);
		wr(`RUM_SEL_ASSOC, 1'b1, 64'h5, 1'b0);
		wr(`RUM_SEL_EVTSEL, 1'b0, 64'h0000_0040_0000_0001, 1'b1);
		wr(`RUM_SEL_EVTSEL, 1'b0, 64'h0000_0000_0000_0401, 1'b1);
		wr(`RUM_SEL_CTR, 1'b0, 64'h0, 1'b1);
		wr(`RUM_SEL_EVTSEL, 1'b0, 64'h0000_0009_0000_0003, 1'b0);
		rdck(`RUM_SEL_EVTSEL, 1'b0, 64'h0000_0009_0000_0003);
		ctr(1'b0, 6'h9, `RUM_EVT_OCC, 64'h4000_0000_0000_0000);
		foreach (bad[i]) ctr(1'b0, 6'h5, bad[i], 64'h8000_0000_0000_0000);
		ops(2'h3, 2'h0, 2'h0, 3, 6'h5);
		evict_tag = 6'h5;
		evict_valid = 1'b1;
		@(negedge core_clk);
		evict_valid = 1'b0;
		repeat (2) @(negedge core_clk);
		ctr(1'b1, 6'h5, `RUM_EVT_OCC, 64'h5);
		ops(2'h0, 2'h1, 2'h0, 3, 6'h5);
		ctr(1'b0, 6'h5, `RUM_EVT_TOT, 64'h3);
		ops(2'h0, 2'h0, 2'h2, 2, 6'h5);
		ctr(1'b0, 6'h5, `RUM_EVT_LOC, 64'h2);
		wr(`RUM_SEL_ASSOC, 1'b0, 64'h7, 1'b0);
		ops(2'h0, 2'h1, 2'h0, (1 << BW) + 2, 6'h7);
		ctr(1'b0, 6'h7, `RUM_EVT_TOT, 64'h2000_0000_0000_0002);
		rdck(`RUM_SEL_CTR, 1'b0, 64'h2);
		acc(1'b0, 2'h3, 1'b0, 64'h0);
		chk_flag(flt, 1'b1);
		rst_n = 1'b0;
		@(negedge core_clk);
		rst_n = 1'b1;
		rdck(`RUM_SEL_ASSOC, 1'b0, 64'h0);
		ctr(1'b0, 6'h7, `RUM_EVT_TOT, 64'h4000_0000_0000_0000);
		stop_test();
	end
endmodule : test_rum_top
`default_nettype wire
